/* rtl/kpi_input_irq.sv */
/*
 * Key and port input interrupt front end with AXI4-Lite register slave.
 * Assumes all pins synchronous-safe after the two-stage synchroniser,
 * a CPU that takes int_req/int_level/int_vector, and an external DMA
 * engine that pulses dma_done when a triggered transfer finishes.
 */
// The AXI4-Lite register port is this design's own decision.
// Function
// - Key one group chosen by select bits 3:2
// - Key zero group chosen by select bits 1:0
// - Masked key pins never affect the condition
// - Compare bit gives per-pin active transition
// - Flag set on match turning into mismatch
// - Mismatch to mismatch never sets key flag
// - Flags set regardless of enable bit
// - Request needs flag and enable both set
// - Highest pending priority level presented only
// - Even level bits 2:0, odd bits 6:4
// - DMA mode triggers transfer, flag after done
// - Fixed trap vector offsets per factor
// - Trap table base is software relocatable
// - Each port factor selects one of four pins
// - Edge/level and polarity choose port trigger
`timescale 1ns/1ps
`default_nettype none

module kpi_input_irq
   import kpi_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Input pins
   input  wire logic [4:0]  group_five_pins,
   input  wire logic [7:0]  group_six_pins,
   input  wire logic [7:0]  port0_pins,
   input  wire logic [7:0]  port2_pins,
   input  wire logic [3:0]  port3_pins,
   // Intelligent DMA, bit i drives channel of port factor i
   output logic [7:0]       dma_trigger,
   input  wire logic [7:0]  dma_done,
   // CPU interrupt request
   output logic             int_req,
   output logic [2:0]       int_level,
   output logic [3:0]       int_factor,
   output logic [31:0]      int_vector
);

   ////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic hit(input logic [31:0] addr, input logic [29:0] idx);
      hit = (addr[31:2] == idx);
   endfunction : hit

   function automatic logic [31:0] vec_offset(input int idx);
      if (idx < 4) begin
         vec_offset = VEC_PORT_LO + 32'(idx * 4);
      end else if (idx < 8) begin
         vec_offset = VEC_PORT_HI + 32'((idx - 4) * 4);
      end else begin
         vec_offset = VEC_KEY + 32'((idx - 8) * 4);
      end
   endfunction : vec_offset

   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  prio01, prio23, priokey, prio45, prio67;
   logic [7:0]  en03, en47, dreq03, dreq47, den03, den47;
   logic [7:0]  psel1, psel2, pol, edge_sel, ksel;
   logic [4:0]  key0_pin_mask, key0_compare;
   logic [3:0]  key1_pin_mask, key1_compare;
   logic [31:0] trap_base_reg;
   logic [9:0]  flags;
   logic [31:0] rd_word;
   logic        rd_known;
   wire         wr_known;

   ////////////////////////////////////////////////////////////////////
   // Bus handshake
   wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire rd_take = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   wire rd_fire = s_axi_arvalid & s_axi_arready;
   wire wb0     = wr_fire & s_axi_wstrb[0];
   wire [7:0] wd = s_axi_wdata[7:0];

   wire w_prio01 = wb0 & hit(s_axi_awaddr, IDX_PRIO01);
   wire w_prio23 = wb0 & hit(s_axi_awaddr, IDX_PRIO23);
   wire w_priok  = wb0 & hit(s_axi_awaddr, IDX_PRIOKEY);
   wire w_prio45 = wb0 & hit(s_axi_awaddr, IDX_PRIO45);
   wire w_prio67 = wb0 & hit(s_axi_awaddr, IDX_PRIO67);
   wire w_en03   = wb0 & hit(s_axi_awaddr, IDX_EN03);
   wire w_en47   = wb0 & hit(s_axi_awaddr, IDX_EN47);
   wire w_flag03 = wb0 & hit(s_axi_awaddr, IDX_FLAG03);
   wire w_flag47 = wb0 & hit(s_axi_awaddr, IDX_FLAG47);
   wire w_dreq03 = wb0 & hit(s_axi_awaddr, IDX_DREQ03);
   wire w_dreq47 = wb0 & hit(s_axi_awaddr, IDX_DREQ47);
   wire w_den03  = wb0 & hit(s_axi_awaddr, IDX_DEN03);
   wire w_den47  = wb0 & hit(s_axi_awaddr, IDX_DEN47);
   wire w_psel1  = wb0 & hit(s_axi_awaddr, IDX_PSEL1);
   wire w_psel2  = wb0 & hit(s_axi_awaddr, IDX_PSEL2);
   wire w_pol    = wb0 & hit(s_axi_awaddr, IDX_POL);
   wire w_edge   = wb0 & hit(s_axi_awaddr, IDX_EDGE);
   wire w_ksel   = wb0 & hit(s_axi_awaddr, IDX_KSEL);
   wire w_kmask0 = wb0 & hit(s_axi_awaddr, IDX_KMASK0);
   wire w_kmask1 = wb0 & hit(s_axi_awaddr, IDX_KMASK1);
   wire w_kcmp0  = wb0 & hit(s_axi_awaddr, IDX_KCMP0);
   wire w_kcmp1  = wb0 & hit(s_axi_awaddr, IDX_KCMP1);
   wire w_trap   = wr_fire & hit(s_axi_awaddr, IDX_TRAP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         s_axi_awready <= wr_take;
         s_axi_wready  <= wr_take;
         s_axi_arready <= rd_take;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register file; reserved bits are never stored so they read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {prio01, prio23, priokey, prio45, prio67} <= {5{RST_BYTE}};
         {en03, en47, dreq03, dreq47, den03, den47} <= {6{RST_BYTE}};
         {psel1, psel2, pol, edge_sel, ksel} <= {5{RST_BYTE}};
         key0_pin_mask <= 5'h00;
         key0_compare  <= 5'h00;
         key1_pin_mask <= 4'h0;
         key1_compare  <= 4'h0;
         trap_base_reg <= TRAP_BASE_RST;
      end else begin
         if (w_prio01) prio01 <= wd & PRIO_MASK;
         if (w_prio23) prio23 <= wd & PRIO_MASK;
         if (w_priok)  priokey <= wd & PRIO_MASK;
         if (w_prio45) prio45 <= wd & PRIO_MASK;
         if (w_prio67) prio67 <= wd & PRIO_MASK;
         if (w_en03)   en03 <= wd & 8'h3f;
         if (w_en47)   en47 <= wd & 8'h3c;
         if (w_dreq03) dreq03 <= wd & 8'h0f;
         if (w_dreq47) dreq47 <= wd & 8'hf0;
         if (w_den03)  den03 <= wd & 8'h0f;
         if (w_den47)  den47 <= wd & 8'hf0;
         if (w_psel1)  psel1 <= wd;
         if (w_psel2)  psel2 <= wd;
         if (w_pol)    pol <= wd;
         if (w_edge)   edge_sel <= wd;
         if (w_ksel)   ksel <= wd & 8'h0f;
         if (w_kmask0) key0_pin_mask <= wd[4:0];
         if (w_kmask1) key1_pin_mask <= wd[3:0];
         if (w_kcmp0)  key0_compare <= wd[4:0];
         if (w_kcmp1)  key1_compare <= wd[3:0];
         for (int b = 0; b < 4; b++) begin
            if (w_trap && s_axi_wstrb[b]) trap_base_reg[8*b +: 8] <= s_axi_wdata[8*b +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read decode
   wire [7:0] flag03_rd = {2'b00, flags[9], flags[8], flags[3:0]};
   wire [7:0] flag47_rd = {2'b00, flags[7:4], 2'b00};
   wire [31:0] ra = s_axi_araddr;
   wire [31:0] wa = s_axi_awaddr;
   assign wr_known = hit(wa, IDX_PRIO01) | hit(wa, IDX_PRIO23) | hit(wa, IDX_PRIOKEY)
                 | hit(wa, IDX_PRIO45) | hit(wa, IDX_PRIO67) | hit(wa, IDX_EN03)
                 | hit(wa, IDX_EN47) | hit(wa, IDX_FLAG03) | hit(wa, IDX_FLAG47)
                 | hit(wa, IDX_DREQ03) | hit(wa, IDX_DREQ47) | hit(wa, IDX_DEN03)
                 | hit(wa, IDX_DEN47) | hit(wa, IDX_PSEL1) | hit(wa, IDX_PSEL2)
                 | hit(wa, IDX_POL) | hit(wa, IDX_EDGE) | hit(wa, IDX_KSEL)
                 | hit(wa, IDX_KMASK0) | hit(wa, IDX_KMASK1) | hit(wa, IDX_KCMP0)
                 | hit(wa, IDX_KCMP1) | hit(wa, IDX_TRAP);

   always_comb begin
      rd_known = 1'b1;
      rd_word  = 32'h0000_0000;
      if (hit(ra, IDX_PRIO01)) rd_word[7:0] = prio01;
      else if (hit(ra, IDX_PRIO23)) rd_word[7:0] = prio23;
      else if (hit(ra, IDX_PRIOKEY)) rd_word[7:0] = priokey;
      else if (hit(ra, IDX_PRIO45)) rd_word[7:0] = prio45;
      else if (hit(ra, IDX_PRIO67)) rd_word[7:0] = prio67;
      else if (hit(ra, IDX_EN03)) rd_word[7:0] = en03;
      else if (hit(ra, IDX_EN47)) rd_word[7:0] = en47;
      else if (hit(ra, IDX_FLAG03)) rd_word[7:0] = flag03_rd;
      else if (hit(ra, IDX_FLAG47)) rd_word[7:0] = flag47_rd;
      else if (hit(ra, IDX_DREQ03)) rd_word[7:0] = dreq03;
      else if (hit(ra, IDX_DREQ47)) rd_word[7:0] = dreq47;
      else if (hit(ra, IDX_DEN03)) rd_word[7:0] = den03;
      else if (hit(ra, IDX_DEN47)) rd_word[7:0] = den47;
      else if (hit(ra, IDX_PSEL1)) rd_word[7:0] = psel1;
      else if (hit(ra, IDX_PSEL2)) rd_word[7:0] = psel2;
      else if (hit(ra, IDX_POL)) rd_word[7:0] = pol;
      else if (hit(ra, IDX_EDGE)) rd_word[7:0] = edge_sel;
      else if (hit(ra, IDX_KSEL)) rd_word[7:0] = ksel;
      else if (hit(ra, IDX_KMASK0)) rd_word[4:0] = key0_pin_mask;
      else if (hit(ra, IDX_KMASK1)) rd_word[3:0] = key1_pin_mask;
      else if (hit(ra, IDX_KCMP0)) rd_word[4:0] = key0_compare;
      else if (hit(ra, IDX_KCMP1)) rd_word[3:0] = key1_compare;
      else if (hit(ra, IDX_TRAP)) rd_word = trap_base_reg;
      else rd_known = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Pin synchroniser; second stage is the only reader of the first
   logic [32:0] sync1, sync2;
   // Reset zeros are not pin levels; events wait until flops and history are real
   logic [2:0]  pins_live;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1     <= 33'h0_0000_0000;
         sync2     <= 33'h0_0000_0000;
         pins_live <= 3'h0;
      end else begin
         sync1 <= {port3_pins, port2_pins, port0_pins, group_six_pins, group_five_pins};
         sync2 <= sync1;
         pins_live <= {pins_live[1:0], 1'b1};
      end
   end
   wire [4:0] k5s = sync2[4:0];
   wire [7:0] k6s = sync2[12:5];
   wire [7:0] p0s = sync2[20:13];
   wire [7:0] p2s = sync2[28:21];
   wire [3:0] p3s = sync2[32:29];

   ////////////////////////////////////////////////////////////////////
   // Port input factors
   wire [15:0] psel = {psel2, psel1};
   wire [7:0]  sel_pin;
   wire [7:0]  port_evt;
   logic [7:0] pin_prev;
   for (genvar i = 0; i < 8; i++) begin : g_port
      wire [1:0] code = psel[2*i +: 2];
      wire       alt;
      if (i < 5) begin : g_lo
         assign alt = k5s[i];
      end else begin : g_hi
         assign alt = p3s[i-4];
      end
      assign sel_pin[i] = (code == 2'h3) ? p2s[i] : (code == 2'h2) ? p0s[i]
                        : (code == 2'h1) ? alt : k6s[i];
      assign port_evt[i] = pins_live[2] & (edge_sel[i]
                         ? (pol[i] ? (sel_pin[i] & ~pin_prev[i]) : (~sel_pin[i] & pin_prev[i]))
                         : (sel_pin[i] == pol[i]));
   end

   ////////////////////////////////////////////////////////////////////
   // Key input factors
   wire [1:0] ks0 = ksel[KSEL0_LSB +: 2];
   wire [1:0] ks1 = ksel[KSEL1_LSB +: 2];
   wire [4:0] key0_in = (ks0 == 2'h3) ? p2s[4:0] : (ks0 == 2'h2) ? p0s[4:0]
                      : (ks0 == 2'h1) ? k6s[4:0] : k5s;
   wire [3:0] key1_in = (ks1 == 2'h3) ? p2s[7:4] : (ks1 == 2'h2) ? p0s[7:4]
                      : (ks1 == 2'h1) ? k6s[7:4] : k6s[3:0];
   // Compare bit is the pin's idle level, so leaving it is the active edge
   wire key0_match = (((key0_in ^ key0_compare) & key0_pin_mask) == 5'h00);
   wire key1_match = (((key1_in ^ key1_compare) & key1_pin_mask) == 4'h0);
   logic key0_was_match, key1_was_match;
   wire key0_evt = pins_live[2] & key0_was_match & ~key0_match;
   wire key1_evt = pins_live[2] & key1_was_match & ~key1_match;

   ////////////////////////////////////////////////////////////////////
   // Factor flags; a set in the clearing cycle wins
   wire [7:0] dma_mode = (dreq47 | dreq03) & (den47 | den03);
   wire [9:0] set_vec  = {key1_evt, key0_evt,
                          (port_evt & ~dma_mode) | (dma_done & dma_mode)};
   wire [9:0] clr_vec  = {w_flag03 & wd[KEY1_BIT], w_flag03 & wd[KEY0_BIT],
                          {4{w_flag47}} & wd[PORT_HI_LSB +: 4], {4{w_flag03}} & wd[3:0]};
   wire [9:0] next_flags = (flags & ~clr_vec) | set_vec;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags          <= 10'h000;
         pin_prev       <= 8'h00;
         key0_was_match <= 1'b0;
         key1_was_match <= 1'b0;
         dma_trigger    <= 8'h00;
      end else begin
         flags          <= next_flags;
         pin_prev       <= sel_pin;
         key0_was_match <= key0_match;
         key1_was_match <= key1_match;
         dma_trigger    <= port_evt & dma_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Priority selection toward the CPU
   wire [9:0] enables = {en03[KEY1_BIT], en03[KEY0_BIT], en47[PORT_HI_LSB +: 4], en03[3:0]};
   wire [9:0] pend    = flags & enables;
   wire [2:0] lvl [10];
   assign lvl[0] = prio01[LVL_EVEN_LSB +: 3];
   assign lvl[1] = prio01[LVL_ODD_LSB +: 3];
   assign lvl[2] = prio23[LVL_EVEN_LSB +: 3];
   assign lvl[3] = prio23[LVL_ODD_LSB +: 3];
   assign lvl[4] = prio45[LVL_EVEN_LSB +: 3];
   assign lvl[5] = prio45[LVL_ODD_LSB +: 3];
   assign lvl[6] = prio67[LVL_EVEN_LSB +: 3];
   assign lvl[7] = prio67[LVL_ODD_LSB +: 3];
   assign lvl[8] = priokey[LVL_EVEN_LSB +: 3];
   assign lvl[9] = priokey[LVL_ODD_LSB +: 3];

   logic        best_found;
   logic [2:0]  best_lvl;
   logic [3:0]  best_idx;
   logic [31:0] best_off;
   // Ties go to the lower factor number; a fixed order keeps it simple
   always_comb begin
      best_found = 1'b0;
      best_lvl   = 3'h0;
      best_idx   = 4'h0;
      best_off   = 32'h0000_0000;
      for (int j = 0; j < 10; j++) begin
         if (pend[j] && (!best_found || lvl[j] > best_lvl)) begin
            best_found = 1'b1;
            best_lvl   = lvl[j];
            best_idx   = 4'(j);
            best_off   = vec_offset(j);
         end
      end
   end

   // CPU side still applies its own enable and level gate on these
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_req    <= 1'b0;
         int_level  <= 3'h0;
         int_factor <= 4'h0;
         int_vector <= TRAP_BASE_RST;
      end else begin
         int_req    <= best_found;
         int_level  <= best_lvl;
         int_factor <= best_idx;
         int_vector <= trap_base_reg + best_off;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   logic [2:0] max_pend_lvl;
   always_comb begin
      max_pend_lvl = 3'h0;
      for (int j = 0; j < 10; j++) begin
         if (pend[j] && lvl[j] > max_pend_lvl) max_pend_lvl = lvl[j];
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   key_set_a: assert property (pins_live[2] && key0_was_match && !key0_match |=> flags[8])
      else $error("key flag missed on match to mismatch");
   key_quiet_a: assert property ($rose(flags[8]) |-> $past(key0_was_match && !key0_match))
      else $error("key flag set without match to mismatch");
   key_masked_a: assert property ($stable(key0_pin_mask) && key0_pin_mask == 5'h00
                                  && !flags[8] && !$past(w_kcmp0) |=> !flags[8])
      else $error("fully masked key group set its flag");
   flag_indep_a: assert property (port_evt[0] && !dma_mode[0] && !en03[0] |=> flags[0])
      else $error("port flag not set while disabled");
   req_enable_a: assert property (int_req |-> ($past(pend) & (10'h001 << int_factor)) != 10'h000)
      else $error("request for factor not pending and enabled");
   prio_top_a: assert property (int_req |-> int_level == $past(max_pend_lvl))
      else $error("presented level below highest pending");
   dma_route_a: assert property (dma_mode[0] && port_evt[0] && !dma_done[0] && !flags[0]
                                 |=> dma_trigger[0] && !flags[0])
      else $error("dma factor did not trigger or raised flag");
   key_vec_a: assert property (int_req && int_factor == 4'h8
                               |-> int_vector == $past(trap_base_reg) + VEC_KEY)
      else $error("key zero trap vector wrong");
   level_low_a: assert property (pins_live[2] && !edge_sel[0] && !pol[0] && !sel_pin[0]
                                 && !dma_mode[0] |=> flags[0])
      else $error("low level did not set port flag");

   key_event_c: cover property (key1_evt ##1 flags[9]);
   dma_path_c: cover property (dma_trigger[0] ##[1:20] dma_done[0]);
   two_pend_c: cover property (int_req && $countones(pend) > 1);

endmodule : kpi_input_irq

`default_nettype wire

/* rtl/kpi_pkg.sv */
/*
 * Package for the key and port input interrupt front end: register
 * indices, field positions, reset values and trap vector offsets.
 * Assumes a 32-bit AXI4-Lite register bus; byte address is four times
 * the register index.
 */
package kpi_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register indices (byte address = index * 4)
   localparam logic [29:0] IDX_PRIO01  = 30'h0004_0260;
   localparam logic [29:0] IDX_PRIO23  = 30'h0004_0261;
   localparam logic [29:0] IDX_PRIOKEY = 30'h0004_0262;
   localparam logic [29:0] IDX_PRIO45  = 30'h0004_026c;
   localparam logic [29:0] IDX_PRIO67  = 30'h0004_026d;
   localparam logic [29:0] IDX_EN03    = 30'h0004_0270;
   localparam logic [29:0] IDX_EN47    = 30'h0004_0277;
   localparam logic [29:0] IDX_FLAG03  = 30'h0004_0280;
   localparam logic [29:0] IDX_FLAG47  = 30'h0004_0287;
   localparam logic [29:0] IDX_DREQ03  = 30'h0004_0290;
   localparam logic [29:0] IDX_DREQ47  = 30'h0004_0293;
   localparam logic [29:0] IDX_DEN03   = 30'h0004_0294;
   localparam logic [29:0] IDX_DEN47   = 30'h0004_0297;
   localparam logic [29:0] IDX_PSEL1   = 30'h0004_02c6;
   localparam logic [29:0] IDX_PSEL2   = 30'h0004_02c7;
   localparam logic [29:0] IDX_POL     = 30'h0004_02c8;
   localparam logic [29:0] IDX_EDGE    = 30'h0004_02c9;
   localparam logic [29:0] IDX_KSEL    = 30'h0004_02ca;
   localparam logic [29:0] IDX_KMASK0  = 30'h0004_02cc;
   localparam logic [29:0] IDX_KMASK1  = 30'h0004_02cd;
   localparam logic [29:0] IDX_KCMP0   = 30'h0004_02ce;
   localparam logic [29:0] IDX_KCMP1   = 30'h0004_02cf;
   localparam logic [29:0] IDX_TRAP    = 30'h0004_8134;

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int LVL_EVEN_LSB = 0;
   localparam int LVL_ODD_LSB  = 4;
   localparam int KEY0_BIT     = 4;
   localparam int KEY1_BIT     = 5;
   localparam int PORT_HI_LSB  = 2;
   localparam int DMA_HI_LSB   = 4;
   localparam int KSEL0_LSB    = 0;
   localparam int KSEL1_LSB    = 2;
   localparam logic [7:0] PRIO_MASK = 8'h77;

   ////////////////////////////////////////////////////////////////////
   // Reset values and trap vectors
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [31:0] TRAP_BASE_RST = 32'h00c0_0000;
   localparam logic [31:0] VEC_PORT_LO   = 32'h0000_0040;
   localparam logic [31:0] VEC_KEY       = 32'h0000_0050;
   localparam logic [31:0] VEC_PORT_HI   = 32'h0000_0110;

   ////////////////////////////////////////////////////////////////////
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : kpi_pkg

/* tb/kpi_dma_model.sv */
/* Far-side DMA engine stand-in: for lat up to 13 a trigger is answered by a one-cycle done pulse
   lat+3 cycles after it unless a new trigger restarts the count first; above that the 4-bit count wraps. Assumes the bench's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module kpi_dma_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Trigger and completion
   input  wire logic [7:0] dma_trigger,
   input  wire logic [3:0] lat,
   output logic      [7:0] dma_done
);
   logic [3:0] cnt [8];
   // Latency input lets the bench make the transfer prompt or slow
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 8; i++) begin
         if (!aresetn) begin
            cnt[i]      <= 4'h0;
            dma_done[i] <= 1'b0;
         end else begin
            dma_done[i] <= (cnt[i] == 4'h1);
            if (dma_trigger[i]) cnt[i] <= lat + 4'h2;
            else if (cnt[i] != 4'h0) cnt[i] <= cnt[i] - 4'h1;
         end
      end
   end
endmodule : kpi_dma_model
`default_nettype wire

/* tb/tb.sv */
/* Self-checking bench for the input interrupt front end.
   Assumes the package register indices and the hand-over timing. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import kpi_pkg::*;
   logic aclk = 0, aresetn = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, int_req;
   logic [1:0] bresp, rresp;
   logic [3:0] wstrb = 4'hf, int_factor, p3 = 0, lat = 0;
   logic [4:0] g5 = 5'h1f;
   logic [7:0] g6 = 8'hff, p0 = 0, p2 = 0, trig, done;
   logic [2:0] int_level;
   logic [31:0] vec;
   logic [15:0] rnd = 16'd10364;
   int error_cnt = 0, total_checks = 0;
   always #5 aclk = ~aclk;
   kpi_input_irq kpi_input_irq_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .group_five_pins(g5), .group_six_pins(g6),
      .port0_pins(p0), .port2_pins(p2), .port3_pins(p3), .dma_trigger(trig),
      .dma_done(done), .int_req(int_req), .int_level(int_level),
      .int_factor(int_factor), .int_vector(vec));
   kpi_dma_model kpi_dma_model_inst (.aclk(aclk), .aresetn(aresetn), .dma_trigger(trig),
      .lat(lat), .dma_done(done));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Write waits for awready (wready comes in the same cycle), then for bvalid
   task automatic axw(input logic [29:0] idx, input logic [31:0] d, input logic [1:0] rs);
      @(posedge aclk);
      awaddr <= {idx, 2'b00}; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0; wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, rs}, {30'h0, bresp});
   endtask : axw
   task automatic axr(input logic [29:0] idx, input logic [31:0] e, input logic [1:0] rs);
      @(posedge aclk);
      araddr <= {idx, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", e, rdata);
      chk("rresp", {30'h0, rs}, {30'h0, rresp});
   endtask : axr
   task automatic wait_req(input logic want);
      for (int i = 0; i < 12 && int_req !== want; i++) @(posedge aclk);
      chk("int_req", {31'h0, want}, {31'h0, int_req});
   endtask : wait_req
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(IDX_TRAP, TRAP_BASE_RST, RESP_OKAY);
      axr(30'h0000_0123, 32'h0, RESP_SLVERR);
      axw(30'h0000_0123, 32'hff, RESP_SLVERR);
      // Random levels; reserved bits 3 and 7 must read back zero
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr_next(rnd);
         p2 <= rnd[15:8]; p0 <= rnd[7:0]; p3 <= rnd[3:0]; lat <= rnd[11:8];
         axw(IDX_PRIO01, {24'h0, rnd[7:0]}, RESP_OKAY);
         axr(IDX_PRIO01, {24'h0, rnd[7:0] & PRIO_MASK}, RESP_OKAY);
      end
      // Port factor 0, rising edge on group six bit 0, relocated base
      axw(IDX_TRAP, 32'h0020_0000, RESP_OKAY);
      axw(IDX_EDGE, 32'h01, RESP_OKAY);
      axw(IDX_POL, 32'h01, RESP_OKAY);
      axw(IDX_EN03, 32'h01, RESP_OKAY);
      g6 <= 8'hfe;
      repeat (6) @(posedge aclk);
      axr(IDX_FLAG03, 32'h0, RESP_OKAY);
      g6 <= 8'hff;
      wait_req(1'b1);
      chk("level", {29'h0, rnd[2:0]}, {29'h0, int_level});
      chk("factor", 32'h0, {28'h0, int_factor});
      chk("vector", 32'h0020_0040, vec);
      axw(IDX_FLAG03, 32'h01, RESP_OKAY);
      wait_req(1'b0);
      // Key zero on group five: pin 0 masked, compare is the idle level
      axw(IDX_KCMP0, 32'h1f, RESP_OKAY);
      axw(IDX_KMASK0, 32'h1e, RESP_OKAY);
      axw(IDX_EN03, 32'h00, RESP_OKAY);
      g5 <= 5'h1e;
      repeat (6) @(posedge aclk);
      axr(IDX_FLAG03, 32'h0, RESP_OKAY);
      g5 <= 5'h16;
      repeat (6) @(posedge aclk);
      chk("int_req", 32'h0, {31'h0, int_req});
      axr(IDX_FLAG03, 32'h10, RESP_OKAY);
      axw(IDX_EN03, 32'h10, RESP_OKAY);
      wait_req(1'b1);
      chk("factor", 32'h8, {28'h0, int_factor});
      chk("vector", 32'h0020_0050, vec);
      axw(IDX_FLAG03, 32'h10, RESP_OKAY);
      g5 <= 5'h14;
      repeat (6) @(posedge aclk);
      axr(IDX_FLAG03, 32'h0, RESP_OKAY);
      // Port factor 0 on low level: flag holds while the pin stays low
      axw(IDX_POL, 32'h00, RESP_OKAY);
      axw(IDX_EDGE, 32'h00, RESP_OKAY);
      g6 <= 8'hfe;
      repeat (6) @(posedge aclk);
      axr(IDX_FLAG03, 32'h01, RESP_OKAY);
      g6 <= 8'hff;
      repeat (3) @(posedge aclk);
      axw(IDX_FLAG03, 32'h01, RESP_OKAY);
      axr(IDX_FLAG03, 32'h0, RESP_OKAY);
      axw(IDX_EDGE, 32'h01, RESP_OKAY);
      axw(IDX_POL, 32'h01, RESP_OKAY);
      // Port factor 0 in DMA mode: trigger first, flag only after done
      axw(IDX_DREQ03, 32'h01, RESP_OKAY);
      axw(IDX_DEN03, 32'h01, RESP_OKAY);
      axw(IDX_EN03, 32'h01, RESP_OKAY);
      g6 <= 8'hfe;
      repeat (4) @(posedge aclk);
      g6 <= 8'hff;
      for (int i = 0; i < 12 && trig[0] !== 1'b1; i++) @(posedge aclk);
      chk("trigger", 32'h1, {31'h0, trig[0]});
      chk("int_req", 32'h0, {31'h0, int_req});
      for (int i = 0; i < 20 && done[0] !== 1'b1; i++) @(posedge aclk);
      chk("done", 32'h1, {31'h0, done[0]});
      wait_req(1'b1);
      axr(IDX_FLAG03, 32'h01, RESP_OKAY);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
